// file: design/ecq_top.sv
`timescale 1ns/1ps
module ecq_top #(
    parameter logic [1:0] QD_KIND = ecq_pkg::QD_SELECT
) (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        event_input_pin,
    input  wire logic        direction_pulse_pin_in,
    output logic             direction_pulse_pin_out,
    output logic             direction_pulse_pin_oe,
    input  wire logic        preceding_a_channel_ovf,
    input  wire logic        peer_b_timer_two_ovf,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [ecq_pkg::CTRL_W-1:0] ctrl;
        logic [ecq_pkg::CNT_W-1:0]  reload;
        logic [ecq_pkg::CNT_W-1:0]  count;
        logic                       irq_req;
        logic                       irq_mask;
        logic                       waitreq;
        logic [31:0]                readdata;
        logic                       irq;
        logic                       pulse_out;
        logic                       pulse_oe;
    } ecq_top_state_t;

    ecq_top_state_t r;
    ecq_top_state_t next_r;

    logic           in_lvl;
    logic           dir_lvl;
    logic           two_phase;
    logic           x4;
    logic           free_run;
    logic           req;
    logic           do_write;
    logic           wrap_up;
    logic           wrap_dn;
    logic           wrap;
    logic [31:0]    rd_mux;
    logic [4:0]     word_addr;
    logic           take;
    logic           sel_count;
    logic           cnt_step;
    logic           cnt_load;
    logic           pulse_en;

    ecq_step_if     st_if ();

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    ecq_sync u_sync_in (
        .clk  (clk),
        .nrst (nrst),
        .d    (event_input_pin),
        .q    (in_lvl)
    );

    ecq_sync u_sync_dir (
        .clk  (clk),
        .nrst (nrst),
        .d    (direction_pulse_pin_in),
        .q    (dir_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Mode resolution

    always_comb begin
        case (QD_KIND)
            ecq_pkg::QD_NORMAL: begin
                two_phase = r.ctrl[ecq_pkg::CTRL_TWO_PHASE];
                x4        = 1'b0;
            end
            ecq_pkg::QD_SELECT: begin
                two_phase = r.ctrl[ecq_pkg::CTRL_TWO_PHASE];
                x4        = r.ctrl[ecq_pkg::CTRL_X4];
            end
            ecq_pkg::QD_X4: begin
                two_phase = r.ctrl[ecq_pkg::CTRL_TWO_PHASE];
                x4        = 1'b1;
            end
            default: begin
                two_phase = 1'b0;
                x4        = 1'b0;
            end
        endcase
    end

    assign free_run = r.ctrl[ecq_pkg::CTRL_FREE_RUN] | two_phase;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Step decoder

    ecq_decode u_decode (
        .clk          (clk),
        .nrst         (nrst),
        .in_lvl       (in_lvl),
        .dir_lvl      (dir_lvl),
        .prev_a_ovf   (preceding_a_channel_ovf),
        .b_two_ovf    (peer_b_timer_two_ovf),
        .src_sel      (r.ctrl[ecq_pkg::CTRL_SRC_HI:ecq_pkg::CTRL_SRC_LO]),
        .two_phase    (two_phase),
        .x4           (x4),
        .up_flag      (r.ctrl[ecq_pkg::CTRL_UP]),
        .dir_from_pin (r.ctrl[ecq_pkg::CTRL_DIR_PIN]),
        .st           (st_if.src)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus helpers

    function automatic logic [31:0] ecq_merge(
        input logic [31:0] old_v,
        input logic [31:0] new_v,
        input logic [3:0]  be
    );
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign req       = avs_read | avs_write;
    assign take      = req & r.waitreq;
    assign do_write  = avs_write & ~r.waitreq;
    assign word_addr = {avs_address[4:2], 2'b00};
    assign sel_count = (word_addr == ecq_pkg::ADDR_COUNT);

    ////////////////////////////////////////////////////////////////////////////////////////
    // Readback

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (word_addr)
            ecq_pkg::ADDR_CTRL:   rd_mux[ecq_pkg::CTRL_W-1:0] = r.ctrl;
            ecq_pkg::ADDR_RELOAD: rd_mux[ecq_pkg::CNT_W-1:0]  = r.reload;
            ecq_pkg::ADDR_COUNT:  rd_mux[ecq_pkg::CNT_W-1:0]  = r.count;
            ecq_pkg::ADDR_STATUS: rd_mux[ecq_pkg::STAT_IRQ]   = r.irq_req;
            ecq_pkg::ADDR_MASK:   rd_mux[ecq_pkg::STAT_IRQ]   = r.irq_mask;
            default:              rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Count step and reload

    assign cnt_step = r.ctrl[ecq_pkg::CTRL_START] & st_if.step;
    assign cnt_load = wrap & ~free_run;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Counter wrap detection

    assign wrap_up  = cnt_step & st_if.up & (r.count == ecq_pkg::CNT_MAX);
    assign wrap_dn  = cnt_step & ~st_if.up & (r.count == ecq_pkg::CNT_MIN);
    assign wrap     = wrap_up | wrap_dn;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Pulse output enable

    assign pulse_en = r.ctrl[ecq_pkg::CTRL_PULSE_EN] & ~r.ctrl[ecq_pkg::CTRL_DIR_PIN]
                      & ~two_phase;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [31:0] tmp;
        logic        clr;
        tmp    = 32'h0000_0000;
        clr    = 1'b0;
        next_r = r;

        // Bus handshake: one wait cycle, then the transfer edge
        next_r.waitreq = ~take;
        if (take) begin
            next_r.readdata = avs_read ? rd_mux : 32'h0000_0000;
        end

        // Register writes
        if (do_write) begin
            case (word_addr)
                ecq_pkg::ADDR_CTRL: begin
                    tmp         = ecq_merge({23'h000000, r.ctrl}, avs_writedata,
                                            avs_byteenable);
                    next_r.ctrl = tmp[ecq_pkg::CTRL_W-1:0];
                end
                ecq_pkg::ADDR_RELOAD: begin
                    tmp           = ecq_merge({16'h0000, r.reload}, avs_writedata,
                                              avs_byteenable);
                    next_r.reload = tmp[ecq_pkg::CNT_W-1:0];
                end
                ecq_pkg::ADDR_MASK: begin
                    if (avs_byteenable[0]) begin
                        next_r.irq_mask = avs_writedata[ecq_pkg::STAT_IRQ];
                    end
                end
                ecq_pkg::ADDR_STATUS: begin
                    clr = avs_byteenable[0] & avs_writedata[ecq_pkg::STAT_IRQ];
                end
                default: begin
                    tmp = 32'h0000_0000;
                end
            endcase
        end

        // Counting; the stopped counter keeps its value
        if (cnt_step) begin
            if (cnt_load) begin
                next_r.count = r.reload;
            end else if (st_if.up) begin
                next_r.count = r.count + 16'h0001;
            end else begin
                next_r.count = r.count - 16'h0001;
            end
        end else if (do_write && sel_count) begin
            tmp          = ecq_merge({16'h0000, r.count}, avs_writedata, avs_byteenable);
            next_r.count = tmp[ecq_pkg::CNT_W-1:0];
        end

        // Sticky request, set wins over clear
        next_r.irq_req = (r.irq_req & ~clr) | wrap;

        // Pulse output toggles on each wrap while pulse output is enabled, the pin is not a direction input and two-phase mode is off
        next_r.pulse_oe = pulse_en;
        if (!next_r.pulse_oe) begin
            next_r.pulse_out = 1'b0;
        end else if (wrap) begin
            next_r.pulse_out = ~r.pulse_out;
        end

        next_r.irq = next_r.irq_req & next_r.irq_mask;
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r.ctrl      <= ecq_pkg::CTRL_RST;
            r.reload    <= ecq_pkg::RELOAD_RST;
            r.count     <= ecq_pkg::COUNT_RST;
            r.irq_req   <= ecq_pkg::STAT_RST;
            r.irq_mask  <= ecq_pkg::MASK_RST;
            r.waitreq   <= 1'b1;
            r.readdata  <= 32'h0000_0000;
            r.irq       <= 1'b0;
            r.pulse_out <= 1'b0;
            r.pulse_oe  <= 1'b0;
        end else begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign avs_readdata            = r.readdata;
    assign avs_waitrequest         = r.waitreq;
    assign direction_pulse_pin_out = r.pulse_out;
    assign direction_pulse_pin_oe  = r.pulse_oe;
    assign irq                     = r.irq;

endmodule

// file: design/ecq_pkg.sv
package ecq_pkg;

    localparam int unsigned CNT_W = 16;

    // Register byte offsets
    localparam logic [4:0] ADDR_CTRL   = 5'h00;
    localparam logic [4:0] ADDR_RELOAD = 5'h04;
    localparam logic [4:0] ADDR_COUNT  = 5'h08;
    localparam logic [4:0] ADDR_STATUS = 5'h0c;
    localparam logic [4:0] ADDR_MASK   = 5'h10;

    // Control field positions
    localparam int unsigned CTRL_W         = 9;
    localparam int unsigned CTRL_START     = 0;
    localparam int unsigned CTRL_UP        = 1;
    localparam int unsigned CTRL_DIR_PIN   = 2;
    localparam int unsigned CTRL_SRC_LO    = 3;
    localparam int unsigned CTRL_SRC_HI    = 4;
    localparam int unsigned CTRL_FREE_RUN  = 5;
    localparam int unsigned CTRL_TWO_PHASE = 6;
    localparam int unsigned CTRL_X4        = 7;
    localparam int unsigned CTRL_PULSE_EN  = 8;

    // Status and mask field position
    localparam int unsigned STAT_IRQ = 0;

    // Reset values
    localparam logic [CTRL_W-1:0] CTRL_RST   = 9'h000;
    localparam logic [CNT_W-1:0]  RELOAD_RST = 16'hffff;
    localparam logic [CNT_W-1:0]  COUNT_RST  = 16'h0000;
    localparam logic              STAT_RST   = 1'b0;
    localparam logic              MASK_RST   = 1'b0;

    // Count source encodings
    localparam logic [1:0] SRC_FALL   = 2'h0;
    localparam logic [1:0] SRC_RISE   = 2'h1;
    localparam logic [1:0] SRC_PREV_A = 2'h2;
    localparam logic [1:0] SRC_B_TWO  = 2'h3;

    // Two-phase capability of a channel
    localparam logic [1:0] QD_NONE   = 2'h0;
    localparam logic [1:0] QD_NORMAL = 2'h1;
    localparam logic [1:0] QD_SELECT = 2'h2;
    localparam logic [1:0] QD_X4     = 2'h3;

    localparam logic [CNT_W-1:0] CNT_MAX = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_MIN = 16'h0000;

endpackage

// file: design/ecq_step_if.sv
`timescale 1ns/1ps
interface ecq_step_if;
    logic step;
    logic up;

    modport src (output step, output up);
    modport dst (input step, input up);
endinterface

// file: design/ecq_sync.sv
`timescale 1ns/1ps
module ecq_sync (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q
);
    typedef struct packed {
        logic s1;
        logic s2;
    } ecq_sync_state_t;

    ecq_sync_state_t r;
    ecq_sync_state_t next_r;

    always_comb begin
        next_r    = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

// file: design/ecq_decode.sv
`timescale 1ns/1ps
module ecq_decode (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       in_lvl,
    input  wire logic       dir_lvl,
    input  wire logic       prev_a_ovf,
    input  wire logic       b_two_ovf,
    input  wire logic [1:0] src_sel,
    input  wire logic       two_phase,
    input  wire logic       x4,
    input  wire logic       up_flag,
    input  wire logic       dir_from_pin,
    ecq_step_if.src         st
);
    typedef struct packed {
        logic in_d;
        logic dir_d;
        logic prev_d;
        logic btwo_d;
    } ecq_dec_state_t;

    ecq_dec_state_t r;
    ecq_dec_state_t next_r;
    logic a_r, a_f, b_r, b_f, up4, dn4, ev;

    always_comb begin
        next_r        = r;
        next_r.in_d   = in_lvl;
        next_r.dir_d  = dir_lvl;
        next_r.prev_d = prev_a_ovf;
        next_r.btwo_d = b_two_ovf;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign a_r = in_lvl & ~r.in_d;
    assign a_f = ~in_lvl & r.in_d;
    assign b_r = dir_lvl & ~r.dir_d;
    assign b_f = ~dir_lvl & r.dir_d;
    assign up4 = (a_r & dir_lvl) | (a_f & ~dir_lvl) | (b_r & ~in_lvl) | (b_f & in_lvl);
    assign dn4 = (a_f & dir_lvl) | (a_r & ~dir_lvl) | (b_r & in_lvl) | (b_f & ~in_lvl);

    always_comb begin
        ev = 1'b0;
        case (src_sel)
            ecq_pkg::SRC_FALL:   ev = a_f;
            ecq_pkg::SRC_RISE:   ev = a_r;
            ecq_pkg::SRC_PREV_A: ev = prev_a_ovf & ~r.prev_d;
            ecq_pkg::SRC_B_TWO:  ev = b_two_ovf & ~r.btwo_d;
            default:             ev = 1'b0;
        endcase
    end

    always_comb begin
        if (two_phase && x4) begin
            st.step = up4 ^ dn4;
            st.up   = up4;
        end else if (two_phase) begin
            st.step = (a_r | a_f) & dir_lvl;
            st.up   = a_r;
        end else begin
            st.step = ev;
            st.up   = dir_from_pin ? dir_lvl : up_flag;
        end
    end
endmodule

// file: testbench/ecq_chk.sv
`timescale 1ns/1ps
module ecq_chk (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        direction_pulse_pin_oe,
    input wire logic        irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire logic [2:0] wd     = avs_address[4:2];
    wire logic       wr_ok  = avs_write && !avs_waitrequest;
    wire logic       wr_ctl = wr_ok && wd == ecq_pkg::ADDR_CTRL[4:2] && avs_byteenable[1:0] == 2'h3;
    wire logic       wr_msk = wr_ok && wd == ecq_pkg::ADDR_MASK[4:2] && avs_byteenable[0];
    wire logic       wr_irq = wr_msk || (wr_ok && wd == ecq_pkg::ADDR_STATUS[4:2]);
    ////////////////////////////////////////////////////////////////////////////////
    chk_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop");
    chk_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    chk_wait_idle: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest dropped without request");
    chk_unmapped_zero: assert property (avs_read && avs_waitrequest && wd > 3'h4 |=> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    chk_irq_sticky: assert property ($fell(irq) |-> $past(wr_irq) || $past(wr_irq, 2))
        else $error("irq fell without software clear");
    chk_mask_off: assert property (wr_msk && !avs_writedata[0] |-> ##[1:2] !irq)
        else $error("irq high while masked");
    chk_oe_off: assert property (wr_ctl && (avs_writedata[ecq_pkg::CTRL_DIR_PIN]
        || avs_writedata[ecq_pkg::CTRL_TWO_PHASE]) |-> ##[1:2] !direction_pulse_pin_oe)
        else $error("direction pin driven while used as input");
    chk_oe_on: assert property (wr_ctl && avs_writedata[ecq_pkg::CTRL_PULSE_EN]
        && !avs_writedata[ecq_pkg::CTRL_DIR_PIN] && !avs_writedata[ecq_pkg::CTRL_TWO_PHASE]
        |-> ##[1:2] direction_pulse_pin_oe)
        else $error("pulse output not driven");
endmodule

// file: testbench/ecq_src.sv
`timescale 1ns/1ps
module ecq_src (
    input wire logic clk,
    input wire logic nrst,
    input wire logic go,
    input wire logic quad,
    input wire logic fwd,
    input wire logic lvl_b,
    output logic     ph_a,
    output logic     ph_b
);
    logic [1:0] q;
    logic       t;
    // One edge per go request
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= 2'h0;
            t <= 1'b0;
        end else if (go) begin
            if (quad)
                q <= fwd ? q + 2'h1 : q - 2'h1;
            else
                t <= !t;
        end
    end
    // In quad mode the Gray sequence puts both phases on the pins
    assign ph_a = quad ? q[1] : t;
    assign ph_b = quad ? q[1] ^ q[0] : lvl_b;
endmodule

// file: testbench/event_counter_quadrature_bench.sv
`timescale 1ns/1ps
module event_counter_quadrature_bench;
    localparam logic [4:0]  A_CTL = ecq_pkg::ADDR_CTRL;
    localparam logic [4:0]  A_RLD = ecq_pkg::ADDR_RELOAD;
    localparam logic [4:0]  A_CNT = ecq_pkg::ADDR_COUNT;
    localparam logic [4:0]  A_STA = ecq_pkg::ADDR_STATUS;
    localparam logic [4:0]  A_MSK = ecq_pkg::ADDR_MASK;
    localparam logic [31:0] ST    = 32'h1 << ecq_pkg::CTRL_START;
    localparam logic [31:0] UP    = 32'h1 << ecq_pkg::CTRL_UP;
    localparam logic [31:0] DP    = 32'h1 << ecq_pkg::CTRL_DIR_PIN;
    localparam logic [31:0] FR    = 32'h1 << ecq_pkg::CTRL_FREE_RUN;
    localparam logic [31:0] TP    = 32'h1 << ecq_pkg::CTRL_TWO_PHASE;
    localparam logic [31:0] X4    = 32'h1 << ecq_pkg::CTRL_X4;
    localparam logic [31:0] PE    = 32'h1 << ecq_pkg::CTRL_PULSE_EN;
    logic        clk, nrst, avs_read, avs_write, go, quad, fwd, lvl_b, pa_ovf, pb_ovf;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rv;
    logic [31:0] rd_n, rd_x, rv_n, rv_x;
    logic [3:0]  avs_byteenable;
    logic        avs_waitrequest, pin_out, pin_oe, irq, ph_a, ph_b;
    wire logic   dir_wire = pin_oe ? pin_out : ph_b;
    int          fails, checked;
    ////////////////////////////////////////////////////////////////////////////////
    ecq_top ecq_top_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .event_input_pin(ph_a),
        .direction_pulse_pin_in(dir_wire), .direction_pulse_pin_out(pin_out),
        .direction_pulse_pin_oe(pin_oe), .preceding_a_channel_ovf(pa_ovf),
        .peer_b_timer_two_ovf(pb_ovf), .irq);
    ecq_top #(.QD_KIND(ecq_pkg::QD_NORMAL)) ecq_top_normal_inst (.clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(rd_n),
        .avs_waitrequest(), .event_input_pin(ph_a), .direction_pulse_pin_in(dir_wire),
        .direction_pulse_pin_out(), .direction_pulse_pin_oe(),
        .preceding_a_channel_ovf(pa_ovf), .peer_b_timer_two_ovf(pb_ovf), .irq());
    ecq_top #(.QD_KIND(ecq_pkg::QD_X4)) ecq_top_x4_inst (.clk, .nrst, .avs_address,
        .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata(rd_x),
        .avs_waitrequest(), .event_input_pin(ph_a), .direction_pulse_pin_in(dir_wire),
        .direction_pulse_pin_out(), .direction_pulse_pin_oe(),
        .preceding_a_channel_ovf(pa_ovf), .peer_b_timer_two_ovf(pb_ovf), .irq());
    ecq_src ecq_src_inst (.clk, .nrst, .go, .quad, .fwd, .lvl_b, .ph_a, .ph_b);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rv = avs_readdata;
        rv_n = rd_n;
        rv_x = rd_x;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rc(input string n, input logic [4:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(n, rv, e);
    endtask
    task automatic mv(input logic q, input logic f, input int n);
        repeat (n) begin
            go <= 1'b1;
            quad <= q;
            fwd <= f;
            @(posedge clk);
            go <= 1'b0;
            repeat (7) @(posedge clk);
        end
    endtask
    task automatic ov(input logic b);
        if (b)
            pb_ovf <= 1'b1;
        else
            pa_ovf <= 1'b1;
        @(posedge clk);
        pa_ovf <= 1'b0;
        pb_ovf <= 1'b0;
        repeat (4) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        {nrst, avs_read, avs_write, go, quad, fwd, lvl_b, pa_ovf, pb_ovf} = 9'h0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        // Reset values and unmapped read
        rc("ctrl", A_CTL, 32'(ecq_pkg::CTRL_RST));
        rc("reload", A_RLD, 32'(ecq_pkg::RELOAD_RST));
        rc("count", A_CNT, 32'(ecq_pkg::COUNT_RST));
        rc("status", A_STA, 32'(ecq_pkg::STAT_RST));
        rc("mask", A_MSK, 32'(ecq_pkg::MASK_RST));
        rc("unmapped", 5'h14, 32'h0);
        // Every count source
        for (int s = 0; s < 4; s++) begin
            wr(A_CNT, 32'h0);
            wr(A_CTL, ST | UP | (32'(s) << ecq_pkg::CTRL_SRC_LO));
            if (s < 2) begin
                mv(1'b0, 1'b1, 1);
                rc("src first", A_CNT, 32'(s));
                mv(1'b0, 1'b1, 1);
            end else begin
                ov(s == 2);
                rc("src other", A_CNT, 32'h0);
                ov(s == 3);
            end
            rc("src count", A_CNT, 32'h1);
        end
        // Stop holds the value
        wr(A_CTL, 32'h0);
        mv(1'b0, 1'b1, 2);
        rc("stopped", A_CNT, 32'h1);
        // Direction from pin, then from flag
        wr(A_CNT, 32'h5);
        wr(A_CTL, ST | DP);
        mv(1'b0, 1'b1, 2);
        rc("pin down", A_CNT, 32'h4);
        chk("oe", pin_oe, 32'h0);
        lvl_b <= 1'b1;
        rc("pin held", A_CNT, 32'h4);
        mv(1'b0, 1'b1, 2);
        rc("pin up", A_CNT, 32'h5);
        wr(A_CTL, ST);
        rc("flag held", A_CNT, 32'h5);
        mv(1'b0, 1'b1, 2);
        rc("flag down", A_CNT, 32'h4);
        // Reload type wraps and the interrupt
        wr(A_RLD, 32'h10);
        wr(A_CNT, 32'h0);
        mv(1'b0, 1'b1, 2);
        rc("underflow", A_CNT, 32'h10);
        rc("req", A_STA, 32'h1);
        chk("irq masked", irq, 32'h0);
        wr(A_MSK, 32'h1);
        chk("irq on", irq, 32'h1);
        rc("req sticky", A_STA, 32'h1);
        wr(A_STA, 32'h1);
        chk("irq clear", irq, 32'h0);
        wr(A_CNT, 32'hffff);
        wr(A_CTL, ST | UP);
        mv(1'b0, 1'b1, 2);
        rc("overflow", A_CNT, 32'h10);
        chk("irq ovf", irq, 32'h1);
        wr(A_MSK, 32'h0);
        chk("irq mask", irq, 32'h0);
        // Free-run wraps with pulse output
        wr(A_STA, 32'h1);
        wr(A_CNT, 32'hffff);
        wr(A_CTL, ST | UP | FR | PE);
        @(posedge clk);
        chk("oe on", pin_oe, 32'h1);
        mv(1'b0, 1'b1, 2);
        rc("wrap up", A_CNT, 32'h0);
        rc("req free", A_STA, 32'h1);
        chk("pulse", pin_out, 32'h1);
        wr(A_CTL, ST | FR | PE);
        mv(1'b0, 1'b1, 2);
        rc("wrap down", A_CNT, 32'hffff);
        chk("pulse", pin_out, 32'h0);
        // Two-phase, times four then normal
        wr(A_CTL, 32'h0);
        quad <= 1'b1;
        wr(A_STA, 32'h1);
        wr(A_CNT, 32'h2);
        wr(A_CTL, ST | TP | X4);
        mv(1'b1, 1'b1, 4);
        rc("x4 up", A_CNT, 32'h6);
        chk("normal only up", rv_n, 32'h3);
        mv(1'b1, 1'b0, 8);
        rc("x4 down", A_CNT, 32'hfffe);
        chk("normal only down", rv_n, 32'h1);
        rc("req 2ph", A_STA, 32'h1);
        chk("normal only req", rv_n, 32'h0);
        wr(A_CNT, 32'h2);
        wr(A_CTL, ST | TP);
        mv(1'b1, 1'b1, 4);
        rc("normal up", A_CNT, 32'h3);
        chk("x4 only up", rv_x, 32'h6);
        mv(1'b1, 1'b0, 4);
        rc("normal down", A_CNT, 32'h2);
        chk("x4 only down", rv_x, 32'h2);
        stop_test();
    end
endmodule
bind ecq_top ecq_chk ecq_chk_inst (.clk, .nrst, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .direction_pulse_pin_oe, .irq);
